// ---- shared/bbf_pkg.sv ----
// Purpose: constants and types for the boot-block flash host controller
// Assumes: 100 MHz clk_sys, byte-wide parallel flash bus
// Notes: host side; the flash status register map is kept here for reference
package bbf_pkg;
    // ==========================================
    // flash commands
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_READ_SIG = 8'h90;
    // ==========================================
    // flash status register fields and signature addresses
    localparam int SR_READY = 7;
    localparam int SR_SUSPENDED = 6;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_PROG_FAIL = 4;
    localparam int SR_SUPPLY_LOW = 3;
    localparam logic [17:0] SIG_MFG_ADDR = 18'h00000;
    localparam logic [17:0] SIG_DEV_ADDR = 18'h00001;
    // ==========================================
    // host register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    localparam logic [3:0] REG_FSR = 4'h5;
    // host operation codes in REG_CTRL[3:0]
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROGRAM = 4'h1;
    localparam logic [3:0] OP_ERASE = 4'h2;
    localparam logic [3:0] OP_SUSPEND = 4'h3;
    localparam logic [3:0] OP_RESUME = 4'h4;
    localparam logic [3:0] OP_CLEAR = 4'h5;
    localparam logic [3:0] OP_STATUS = 4'h6;
    localparam logic [3:0] OP_ARRAY = 4'h7;
    localparam logic [3:0] OP_SIG = 4'h8;
    localparam logic [3:0] OP_POWERDOWN = 4'h9;
    localparam logic [3:0] OP_WAKE = 4'hA;
    // ==========================================
    // timing
    localparam int CLK_NS = 10;
    localparam int PULSE_NS = 40;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS = 150;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_NS = 480;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int POLL_LIMIT = 4000;
    // ==========================================
    // types
    typedef struct packed {
        logic [16:0] addr;
        logic chip_sel_n;
        logic out_drive_n;
        logic write_n;
        logic powerdown_unlock_n;
        logic [7:0] dq_out;
        logic dq_oe;
    } bbf_pins_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bbf_req_t;
endpackage

// ---- logic/bbf_host.sv ----
// Purpose: host controller driving a boot-block flash over its parallel pins
// Assumes: bus timing met by cycle counts at 100 MHz
// Notes: software issues one operation at a time through REG_CTRL
`timescale 1ns/1ps
module bbf_host
    import bbf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // register port
    input wire bbf_pkg::bbf_req_t req,
    output logic [31:0] rdata,
    // flash pins
    output bbf_pkg::bbf_pins_t pins,
    input wire logic [7:0] dq_in,
    input wire logic supply_high
);
    import bbf_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_WSETUP, ST_WLOW, ST_WHIGH, ST_RSETUP, ST_RWAIT, ST_RHIGH,
        ST_POLL, ST_SLEEP, ST_WAKE
    } bbf_state_t;

    bbf_state_t state_reg, state_next;
    logic [16:0] addr_reg;
    logic [7:0] data_reg, rdata_reg, fsr_reg, cmd_reg;
    logic [3:0] op_reg;
    logic [1:0] step_reg;
    logic [9:0] cnt_reg;
    logic [11:0] poll_reg;
    logic busy_reg, err_reg, timeout_reg, pd_reg;
    logic [7:0] dq_s1, dq_s2;
    logic supply_s1, supply_s2;
    logic [31:0] rd_mux;

    // ==========================================
    // decode
    wire ctrl_wr = req.wr && req.addr == REG_CTRL && !busy_reg;
    wire [3:0] new_op = req.wdata[3:0];
    wire two_step = op_reg == OP_PROGRAM || op_reg == OP_ERASE;
    wire polls = op_reg == OP_PROGRAM || op_reg == OP_ERASE || op_reg == OP_RESUME
        || op_reg == OP_SUSPEND;
    wire cnt_done = cnt_reg == 10'h000;
    // refused: supply low or supply-low bit still set
    wire refuse = (new_op == OP_PROGRAM || new_op == OP_ERASE)
        && (!supply_s2 || fsr_reg[SR_SUPPLY_LOW]);
    // bus floats after the access, so judge on the byte latched inside it
    wire poll_ready = fsr_reg[SR_READY];
    wire [7:0] fsr_clean = {dq_s2[7:3], 3'h0};

    function automatic logic [7:0] first_cmd(input logic [3:0] op);
        case (op)
            OP_PROGRAM: first_cmd = CMD_PROG_SETUP;
            OP_ERASE: first_cmd = CMD_ERASE_SETUP;
            OP_SUSPEND: first_cmd = CMD_SUSPEND;
            OP_RESUME: first_cmd = CMD_CONFIRM;
            OP_CLEAR: first_cmd = CMD_CLEAR_STATUS;
            OP_STATUS: first_cmd = CMD_READ_STATUS;
            OP_SIG: first_cmd = CMD_READ_SIG;
            default: first_cmd = CMD_READ_ARRAY;
        endcase
    endfunction

    assign rd_mux = req.addr == REG_CTRL ? {28'h0, op_reg} :
        req.addr == REG_ADDR ? {15'h0, addr_reg} :
        req.addr == REG_DATA ? {24'h0, data_reg} :
        req.addr == REG_STATUS ? {28'h0, pd_reg, timeout_reg, err_reg, busy_reg} :
        req.addr == REG_RDATA ? {24'h0, rdata_reg} :
        req.addr == REG_FSR ? {24'h0, fsr_reg} : 32'h0;

    // ==========================================
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_wr && !refuse) begin
                    if (new_op == OP_READ) state_next = ST_RSETUP;
                    else if (new_op == OP_POWERDOWN) state_next = ST_SLEEP;
                    else if (new_op == OP_WAKE) state_next = ST_WAKE;
                    else if (new_op <= OP_SIG) state_next = ST_WSETUP;
                end
            end
            ST_WSETUP: state_next = ST_WLOW;
            ST_WLOW: if (cnt_done) state_next = ST_WHIGH;
            ST_WHIGH: begin
                if (cnt_done) begin
                    if (two_step && step_reg == 2'h0) state_next = ST_WSETUP;
                    else if (polls) state_next = ST_POLL;
                    else state_next = ST_IDLE;
                end
            end
            ST_RSETUP: state_next = ST_RWAIT;
            ST_RWAIT: if (cnt_done) state_next = ST_RHIGH;
            ST_RHIGH: begin
                if (cnt_done) begin
                    if (op_reg == OP_READ || poll_ready || poll_reg == 12'h000)
                        state_next = ST_IDLE;
                    else state_next = ST_RSETUP;
                end
            end
            ST_POLL: state_next = ST_RSETUP;
            ST_SLEEP: state_next = ST_IDLE;
            ST_WAKE: if (cnt_done) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
            supply_s1 <= 1'b0;
            supply_s2 <= 1'b0;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            supply_s1 <= supply_high;
            supply_s2 <= supply_s1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            step_reg <= 2'h0;
            cnt_reg <= 10'h000;
            poll_reg <= 12'h000;
            addr_reg <= 17'h00000;
            data_reg <= 8'h00;
            cmd_reg <= 8'h00;
            rdata_reg <= 8'h00;
            fsr_reg <= 8'h00;
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            timeout_reg <= 1'b0;
            pd_reg <= 1'b0;
            rdata <= 32'h0;
        end else begin
            state_reg <= state_next;
            rdata <= req.rd ? rd_mux : 32'h0;
            if (!cnt_done) cnt_reg <= cnt_reg - 10'h001;
            if (req.wr && req.addr == REG_ADDR && !busy_reg) addr_reg <= req.wdata[16:0];
            if (req.wr && req.addr == REG_DATA && !busy_reg) data_reg <= req.wdata[7:0];
            if (ctrl_wr) begin
                op_reg <= new_op;
                err_reg <= refuse;
                timeout_reg <= 1'b0;
                step_reg <= 2'h0;
                poll_reg <= 12'(POLL_LIMIT);
                cmd_reg <= first_cmd(new_op);
                busy_reg <= !refuse && new_op != OP_POWERDOWN;
                if (refuse && !supply_s2) fsr_reg[SR_SUPPLY_LOW] <= 1'b1;
                if (new_op == OP_CLEAR) fsr_reg <= 8'h00;
                if (new_op == OP_WAKE) cnt_reg <= 10'(WAKE_CYC);
            end
            case (state_reg)
                ST_WSETUP: cnt_reg <= 10'(PULSE_CYC);
                ST_WLOW: if (cnt_done) cnt_reg <= 10'(PULSE_CYC);
                ST_WHIGH: if (cnt_done) begin
                    step_reg <= step_reg + 2'h1;
                    // second word: data byte or erase confirm
                    cmd_reg <= op_reg == OP_PROGRAM ? data_reg : CMD_CONFIRM;
                    if (!(two_step && step_reg == 2'h0) && !polls) busy_reg <= 1'b0;
                end
                ST_RSETUP: cnt_reg <= 10'(ACCESS_CYC);
                ST_RWAIT: if (cnt_done) begin
                    cnt_reg <= 10'(PULSE_CYC);
                    if (op_reg == OP_READ) rdata_reg <= dq_s2;
                    else begin
                        fsr_reg <= fsr_clean;
                        poll_reg <= poll_reg - 12'h001;
                    end
                end
                ST_RHIGH: if (cnt_done && state_next == ST_IDLE) begin
                    busy_reg <= 1'b0;
                    timeout_reg <= op_reg != OP_READ && !poll_ready;
                end
                ST_SLEEP: pd_reg <= 1'b1;
                ST_WAKE: begin
                    pd_reg <= 1'b0;
                    if (cnt_done) busy_reg <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // ==========================================
    // pins
    wire writing = state_reg == ST_WSETUP || state_reg == ST_WLOW || state_reg == ST_WHIGH;
    wire reading = state_reg == ST_RSETUP || state_reg == ST_RWAIT;
    // erase address kept on both words so they hit one block
    assign pins.addr = addr_reg;
    assign pins.chip_sel_n = !(writing || reading);
    assign pins.out_drive_n = !reading;
    assign pins.write_n = state_reg != ST_WLOW;
    assign pins.powerdown_unlock_n = !pd_reg;
    assign pins.dq_out = cmd_reg;
    assign pins.dq_oe = writing;
endmodule

// ---- tb/bbf_host_assertions.sv ----
// Purpose: port checks for bbf_host
// Assumes: one clock, resetn low active
// Notes: pulse counts follow the hand-over timing
`timescale 1ns/1ps
module bbf_host_assertions
    import bbf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // watched ports
    input wire bbf_pkg::bbf_req_t req,
    input wire logic [31:0] rdata,
    input wire bbf_pkg::bbf_pins_t pins,
    input wire logic supply_high
);
    import bbf_pkg::*;
    // ====
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic go_erase = req.wr && req.addr == REG_CTRL && req.wdata[3:0] == OP_ERASE;
    sequence s_wlow;
        !pins.write_n [*5] ##1 pins.write_n;
    endsequence
    sequence s_gap;
        (pins.out_drive_n && pins.chip_sel_n) [*4];
    endsequence
    a_write_select: assert property (!pins.write_n |-> !pins.chip_sel_n)
        else $error("write strobe without select");
    a_write_pulse: assert property ($fell(pins.write_n) |-> s_wlow)
        else $error("write strobe length wrong");
    a_write_hold: assert property (!pins.write_n && $past(!pins.write_n)
        |-> $stable(pins.dq_out) && $stable(pins.addr) && pins.dq_oe)
        else $error("write data moved");
    a_no_contend: assert property (!pins.out_drive_n |-> !pins.dq_oe && pins.write_n)
        else $error("host drives during read");
    a_read_len: assert property ($fell(pins.out_drive_n) |-> !pins.out_drive_n [*8])
        else $error("read access too short");
    a_read_gap: assert property ($rose(pins.out_drive_n) |-> s_gap)
        else $error("no gap between reads");
    a_pd_float: assert property (!pins.powerdown_unlock_n |-> pins.chip_sel_n && !pins.dq_oe)
        else $error("bus active in power-down");
    a_low_refuse: assert property (go_erase && !supply_high |-> pins.write_n [*8])
        else $error("erase sent on low supply");
    a_rdata_zero: assert property (!$past(req.rd) |-> rdata == 32'h0)
        else $error("read data outside read slot");
endmodule

// ---- tb/bbf_flash_model.sv ----
// Purpose: behavioural flash device on the bbf_host pins
// Assumes: one block; erase clears all of it
// Notes: engine time kept short for the run
`timescale 1ns/1ps
module bbf_flash_model
    import bbf_pkg::*;
#(
    parameter logic [7:0] MFG_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hC3 // arbitrary value
)
(
    // host pins
    input wire bbf_pkg::bbf_pins_t pins,
    input wire logic supply_high,
    // data back
    output logic [7:0] dq
);
    import bbf_pkg::*;
    // ====
    // device state
    logic [7:0] mem [int];
    logic [7:0] cmdq [$];
    logic [7:0] sr = 8'h80;
    logic [7:0] lat = 8'h80;
    logic [7:0] prev = 8'h00;
    logic [7:0] setup = 8'h00;
    logic [1:0] mode = 2'd0;
    time rdy_t = 0;
    wire logic rd_n = pins.chip_sel_n | pins.out_drive_n;
    wire logic wr_n = pins.chip_sel_n | pins.write_n;
    always @(posedge wr_n) begin
        cmdq.push_back(pins.dq_out);
        if (setup != 8'h00) begin
            mode = 2'd1;
            if (!supply_high) sr[SR_SUPPLY_LOW] = 1'b1;
            else if (setup == CMD_PROG_SETUP) mem[pins.addr] = pins.dq_out;
            else if (pins.dq_out != CMD_CONFIRM) sr[5:4] = 2'b11;
            else mem.delete();
            if (supply_high) sr[SR_READY] = 1'b0;
            rdy_t = $time + 300;
        end else case (pins.dq_out)
            CMD_READ_ARRAY: mode = 2'd0;
            CMD_READ_STATUS: mode = 2'd1;
            CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
            CMD_READ_SIG: mode = 2'd2;
            CMD_SUSPEND: begin
                sr[SR_SUSPENDED] = !sr[SR_READY];
                rdy_t = $time;
                mode = 2'd1;
            end
            CMD_CONFIRM: begin
                sr[7:6] = 2'b00;
                rdy_t = $time + 300;
                mode = 2'd1;
            end
            default: ;
        endcase
        // unknown bus at power-up must not leave the setup latch undefined
        setup = (setup === 8'h00 && (pins.dq_out === CMD_PROG_SETUP
            || pins.dq_out === CMD_ERASE_SETUP)) ? pins.dq_out : 8'h00;
    end
    always #5 if (!sr[SR_READY] && $time >= rdy_t) sr[SR_READY] = 1'b1;
    always @(negedge rd_n) lat = sr;
    always @(negedge pins.powerdown_unlock_n) mode = 2'd0;
    // released bus shows the inverse of the last byte, not a held value
    always #2 begin
        if (!rd_n && pins.powerdown_unlock_n) begin
            if (mode == 2'd1) prev = lat;
            else if (mode == 2'd2) prev = pins.addr[0] ? DEV_CODE : MFG_CODE;
            else prev = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
            dq = prev;
        end else dq = ~prev;
    end
endmodule

// ---- tb/bbf_host_tb.sv ----
// Purpose: self-checking bench for bbf_host
// Assumes: behavioural flash on the pins, seed 43
// Notes: expected bytes kept in exp_mem
`timescale 1ns/1ps
module bbf_host_tb;
    import bbf_pkg::*;
    localparam logic [7:0] MFG = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV = 8'hC3; // arbitrary value
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    bbf_req_t req = '0;
    logic [31:0] rdata;
    bbf_pins_t pins;
    logic [7:0] dq_in;
    logic supply_high = 1'b1;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed = 43;
    int n;
    logic [7:0] exp_mem [int];
    logic [31:0] v;
    logic [16:0] a;
    logic [7:0] d;
    always #5 clk_sys = ~clk_sys;
    bbf_host dut (.clk_sys(clk_sys), .resetn(resetn), .req(req), .rdata(rdata),
        .pins(pins), .dq_in(dq_in), .supply_high(supply_high));
    bbf_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) flash (.pins(pins),
        .supply_high(supply_high), .dq(dq_in));
    // ====
    // tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
        @(posedge clk_sys);
        req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [31:0] rv);
        @(posedge clk_sys);
        req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic op(input logic [3:0] code);
        logic [31:0] s;
        wr(REG_CTRL, {28'h0, code});
        repeat (3) @(posedge clk_sys);
        s = 32'h1;
        for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) rd(REG_STATUS, s);
        check("op done", s & 32'h5, 32'h0);
    endtask
    task automatic readb(input logic [16:0] pa, input logic [31:0] ex);
        wr(REG_ADDR, {15'h0, pa});
        op(OP_READ);
        rd(REG_RDATA, v);
        check("array byte", v, ex);
    endtask
    function automatic logic [31:0] exb(input logic [16:0] pa);
        return exp_mem.exists(pa) ? 32'(exp_mem[pa]) : 32'h0000_00FF;
    endfunction
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            close_out();
        end
    end
    // ====
    // scenarios
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(4'hF, v);
        check("unmapped", v, 32'h0);
        op(OP_ARRAY);
        check("array cmd", 32'(flash.cmdq[$]), 32'(CMD_READ_ARRAY));
        for (int i = 0; i < 4; i++) begin
            a = 17'($random(seed));
            d = 8'($random(seed));
            wr(REG_ADDR, {15'h0, a});
            wr(REG_DATA, {24'h0, d});
            op(OP_PROGRAM);
            exp_mem[a] = d;
            check("setup code", 32'(flash.cmdq[$-1]), 32'(CMD_PROG_SETUP));
            check("data byte", 32'(flash.cmdq[$]), 32'(d));
            rd(REG_FSR, v);
            check("fsr program", v, 32'h80);
        end
        op(OP_ARRAY);
        readb(a, exb(a));
        readb(a ^ 17'h1, exb(a ^ 17'h1));
        op(OP_SIG);
        readb(17'h0, 32'(MFG));
        readb(17'h1, 32'(DEV));
        op(OP_ERASE);
        check("erase setup", 32'(flash.cmdq[$-1]), 32'(CMD_ERASE_SETUP));
        check("erase confirm", 32'(flash.cmdq[$]), 32'(CMD_CONFIRM));
        exp_mem.delete();
        rd(REG_FSR, v);
        check("fsr erase", v, 32'h80);
        op(OP_SUSPEND);
        check("suspend code", 32'(flash.cmdq[$]), 32'(CMD_SUSPEND));
        rd(REG_FSR, v);
        check("fsr suspend", v, 32'h80);
        op(OP_RESUME);
        check("resume code", 32'(flash.cmdq[$]), 32'(CMD_CONFIRM));
        rd(REG_FSR, v);
        check("fsr resume", v, 32'h80);
        op(OP_ARRAY);
        readb(a, exb(a));
        @(posedge clk_sys);
        supply_high <= 1'b0;
        repeat (3) @(posedge clk_sys);
        n = flash.cmdq.size();
        op(OP_ERASE);
        rd(REG_STATUS, v);
        check("refused", v & 32'h2, 32'h2);
        rd(REG_FSR, v);
        check("supply low", v & 32'h8, 32'h8);
        @(posedge clk_sys);
        supply_high <= 1'b1;
        repeat (3) @(posedge clk_sys);
        op(OP_PROGRAM);
        check("no bus writes", flash.cmdq.size(), n);
        op(OP_CLEAR);
        check("clear code", 32'(flash.cmdq[$]), 32'(CMD_CLEAR_STATUS));
        rd(REG_FSR, v);
        check("fsr cleared", v, 32'h0);
        op(OP_STATUS);
        check("status cmd", 32'(flash.cmdq[$]), 32'(CMD_READ_STATUS));
        op(OP_POWERDOWN);
        check("pd pin", 32'(pins.powerdown_unlock_n), 32'h0);
        rd(REG_STATUS, v);
        check("pd flag", v & 32'h8, 32'h8);
        op(OP_WAKE);
        readb(a, 32'hFF);
        close_out();
    end
endmodule
bind bbf_host bbf_host_assertions chk (.clk_sys(clk_sys), .resetn(resetn), .req(req),
    .rdata(rdata), .pins(pins), .supply_high(supply_high));
